// ### inc/lufc_pkg.sv
// Package of the LIN/UART flag, checksum and frame-buffer block.
// Assumes one clock, a synchronous active-low reset and an AXI4-Lite register bus.
package lufc_pkg;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_IREN = 8'h08;
  localparam logic [7:0] OFF_ERR  = 8'h0C;
  localparam logic [7:0] OFF_LEN  = 8'h10;
  localparam logic [7:0] OFF_ID   = 8'h14;
  localparam logic [7:0] OFF_SEL  = 8'h18;
  localparam logic [7:0] OFF_DATA = 8'h1C;

  localparam int CTRL_SWRES = 7;
  localparam int CTRL_OLD   = 6;
  localparam int CTRL_ENA   = 3;
  localparam int STAT_BUSY  = 4;
  localparam int STAT_ERR   = 3;
  localparam int SEL_AINC_N = 3;
  localparam int ERR_ABORT  = 7;
  localparam int ERR_TOUT   = 6;
  localparam int ERR_OVR    = 5;
  localparam int ERR_FRM    = 4;
  localparam int ERR_SYNC   = 3;
  localparam int ERR_PAR    = 2;
  localparam int ERR_CHK    = 1;
  localparam int ERR_BIT    = 0;

  localparam logic [2:0] CMD_RXH_ABORT = 3'h0;
  localparam logic [2:0] CMD_TXH       = 3'h1;
  localparam logic [2:0] CMD_RXR       = 3'h2;
  localparam logic [2:0] CMD_TXR       = 3'h3;

  localparam logic [7:0] CHK_GOOD  = 8'hFF;
  localparam logic [5:0] ID_SPEC   = 6'h3C;
  localparam logic [7:0] ZERO8     = 8'h00;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_SERR = 2'h2;

  typedef enum logic [1:0] {W_IDLE = 2'b01, W_RESP = 2'b10} lufc_wst_t;
  typedef enum logic [1:0] {R_IDLE = 2'b01, R_RESP = 2'b10} lufc_rst_t;

  // Events reported by the serial engine, one-cycle pulses except the byte, level, busy and is_master fields.
  typedef struct packed {
    logic       hdr_done;
    logic       rx_resp_done;
    logic       tx_resp_done;
    logic       uart_rx_char;
    logic       uart_tx_char;
    logic [7:0] uart_rx_byte;
    logic       bit_drive;
    logic       sent_level;
    logic       bus_level;
    logic       stop_sample;
    logic       stop_level;
    logic       sync_fault;
    logic       frame_timeout;
    logic       break_sync;
    logic       resp_byte_valid;
    logic       resp_is_chk;
    logic [7:0] resp_byte;
    logic [2:0] resp_idx;
    logic       id_valid;
    logic [7:0] id_byte;
    logic       busy;
    logic       is_master;
  } lufc_evt_t;

  // Control handed to the serial engine, all from flip-flops.
  typedef struct packed {
    logic       enable;
    logic       old_protocol_select;
    logic [1:0] conf;
    logic [2:0] command_field;
    logic       withdraw;
    logic       bit_abort;
    logic [7:0] uart_tx_byte;
    logic [7:0] tx_checksum;
    logic [3:0] rx_length_field;
    logic [3:0] tx_length_field;
    logic [5:0] id;
  } lufc_ctl_t;

  typedef struct packed {
    lufc_wst_t       wst;
    lufc_rst_t       rst;
    logic [7:0]      awaddr;
    logic            aw_have;
    logic [7:0]      wdata;
    logic            wlane;
    logic            w_have;
    logic [1:0]      bresp;
    logic [7:0]      rdata;
    logic [1:0]      rresp;
    logic [7:0]      ctrl;
    logic [2:0]      okf;
    logic [7:0]      err;
    logic [3:0]      iren;
    logic [3:0]      rxl;
    logic [3:0]      txl;
    logic [5:0]      id;
    logic [2:0]      idst;
    logic [3:0]      sel;
    logic [7:0][7:0] fbuf;
    logic [7:0]      urx;
    logic            urx_full;
    logic [7:0]      utx;
    logic [7:0]      sum;
    logic            withdraw;
    logic            bit_abort;
  } lufc_state_t;

endpackage : lufc_pkg

// ### src/lufc_core.sv
// Flags, errors, checksum, identifier status, interrupts and frame buffer of a LIN/UART controller.
// Assumes a serial engine beside it that reports events as pulses and obeys the control it is given.
`timescale 1ns/100ps
`default_nettype none

module lufc_core
  import lufc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire lufc_evt_t         evt,
  input  wire logic [2:0]        tx_idx,
  output logic [7:0]             tx_buf_byte,
  output lufc_ctl_t              ctl,
  output logic                   irq_err,
  output logic                   irq_com
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Index of a mapped register, or 8 when the address is unmapped.
  function automatic logic [3:0] reg_sel(input logic [7:0] a);
    logic [3:0] r;
    r = 4'h8;
    if (a[1:0] == 2'b00 && a <= OFF_DATA) begin
      r = {1'b0, a[4:2]};
    end
    return r;
  endfunction : reg_sel

  // Eight-bit add with end-around carry.
  function automatic logic [7:0] add_eac(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] t;
    t = {1'b0, a} + {1'b0, b};
    return t[7:0] + {7'h00, t[8]};
  endfunction : add_eac

  // Protected identifier: parity bits over the six identifier bits.
  function automatic logic [7:0] pid(input logic [5:0] i);
    logic p0;
    logic p1;
    p0 = i[0] ^ i[1] ^ i[2] ^ i[4];
    p1 = ~(i[1] ^ i[3] ^ i[4] ^ i[5]);
    return {p1, p0, i};
  endfunction : pid

  // Length coded in identifier bits 5:4 under the old protocol.
  function automatic logic [3:0] old_len(input logic [1:0] c);
    logic [3:0] l;
    case (c)
      2'b10:   l = 4'h4;
      2'b11:   l = 4'h8;
      default: l = 4'h2;
    endcase
    return l;
  endfunction : old_len

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  lufc_state_t s_q;
  lufc_state_t s_d;
  lufc_state_t s_rst;

  logic       uart;
  logic       busy;
  logic [7:0] stat_rd;
  logic       aw_hs;
  logic       w_hs;
  logic       ar_hs;

  always_comb begin
    s_rst          = '0;
    s_rst.wst      = W_IDLE;
    s_rst.rst      = R_IDLE;
    s_rst.bresp    = RESP_OK;
    s_rst.rresp    = RESP_OK;
  end

  assign uart  = s_q.ctrl[2];
  assign busy  = evt.busy;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs  = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign stat_rd = {s_q.idst, busy, |s_q.err, s_q.okf};

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    logic [3:0] wsel;
    logic [3:0] rsel;
    logic [7:0] eset;
    logic       eclr;
    logic [2:0] oset;
    logic [2:0] oclr;
    logic       error_register;
    logic [7:0] wd;
    s_d  = s_q;
    wsel = reg_sel(s_q.awaddr);
    rsel = reg_sel(8'(s_axi_araddr));
    eset = '0;
    eclr = 1'b0;
    oset = '0;
    oclr = '0;
    error_register = 1'b0;
    wd   = s_q.wdata;
    s_d.withdraw  = 1'b0;
    s_d.bit_abort = 1'b0;
    s_d.ctrl[CTRL_SWRES] = 1'b0;

    // Bus handshakes.
    if (aw_hs) begin
      s_d.awaddr  = 8'(s_axi_awaddr);
      s_d.aw_have = 1'b1;
    end
    if (w_hs) begin
      s_d.wdata  = s_axi_wdata[7:0];
      s_d.wlane  = s_axi_wstrb[0];
      s_d.w_have = 1'b1;
    end
    if (s_q.wst == W_RESP && s_axi_bready) begin
      s_d.wst = W_IDLE;
    end
    if (s_q.rst == R_RESP && s_axi_rready) begin
      s_d.rst = R_IDLE;
    end

    // Register read.
    if (ar_hs) begin
      s_d.rst   = R_RESP;
      s_d.rresp = (rsel == 4'h8) ? RESP_SERR : RESP_OK;
      case (rsel)
        4'h0:    s_d.rdata = s_q.ctrl;
        4'h1:    s_d.rdata = stat_rd;
        4'h2:    s_d.rdata = {4'h0, s_q.iren};
        4'h3:    s_d.rdata = s_q.err;
        4'h4:    s_d.rdata = {s_q.txl, s_q.rxl};
        4'h5:    s_d.rdata = pid(s_q.id);
        4'h6:    s_d.rdata = {4'h0, s_q.sel};
        4'h7:    s_d.rdata = uart ? s_q.urx : s_q.fbuf[s_q.sel[2:0]];
        default: s_d.rdata = ZERO8;
      endcase
      if (rsel == 4'h7) begin
        if (uart) begin
          eclr         = 1'b1;
          s_d.urx_full = 1'b0;
        end else if (!s_q.sel[SEL_AINC_N]) begin
          s_d.sel[2:0] = s_q.sel[2:0] + 3'h1;
        end
      end
    end

    // Register write, once address and data are both held.
    if (s_q.wst == W_IDLE && s_q.aw_have && s_q.w_have) begin
      s_d.wst     = W_RESP;
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bresp   = (wsel == 4'h8) ? RESP_SERR : RESP_OK;
      if (s_q.wlane) begin
        case (wsel)
          4'h0: begin
            if (busy) begin
              s_d.ctrl = {wd[7], s_q.ctrl[6:4], wd[3:0]};
              if (!wd[2] && wd[1:0] == CMD_RXH_ABORT[1:0]) begin
                eset[ERR_ABORT] = 1'b1;
              end else if (!wd[2] && wd[3]) begin
                eset[ERR_OVR] = 1'b1;
                s_d.ctrl[2:0] = s_q.ctrl[2:0];
              end
            end else begin
              s_d.ctrl = wd;
            end
            if (!eset[ERR_OVR] && (wd[2:0] == CMD_RXR || wd[2:0] == CMD_TXR)) begin
              s_d.sum = s_d.ctrl[CTRL_OLD] ? ZERO8 : pid(s_q.id);
              if (wd[2:0] == CMD_RXR) begin
                s_d.txl = 4'h0;
              end else begin
                s_d.rxl = 4'h0;
              end
            end
          end
          4'h1: begin
            oclr = wd[2:0];
            eclr = wd[STAT_ERR];
          end
          4'h2: s_d.iren = wd[3:0];
          4'h4: begin
            if (!uart && !busy) begin
              s_d.txl = wd[7:4];
              s_d.rxl = wd[3:0];
            end
          end
          4'h5: begin
            if (!busy) begin
              s_d.id = wd[5:0];
            end
          end
          4'h6: s_d.sel = wd[3:0];
          4'h7: begin
            if (uart) begin
              s_d.utx = wd;
            end else if (!busy) begin
              s_d.fbuf[s_q.sel[2:0]] = wd;
              if (!s_q.sel[SEL_AINC_N]) begin
                s_d.sel[2:0] = s_d.sel[2:0] + 3'h1;
              end
            end
          end
          default: s_d.bresp = RESP_SERR;
        endcase
      end
    end

    // Completion flags.
    if (!uart && evt.hdr_done) begin
      oset[2] = 1'b1;
      if (s_q.ctrl[CTRL_OLD]) begin
        s_d.rxl = old_len(s_q.id[5:4]);
        s_d.txl = old_len(s_q.id[5:4]);
      end
    end
    oset[0] = uart ? evt.uart_rx_char : evt.rx_resp_done;
    oset[1] = uart ? evt.uart_tx_char : evt.tx_resp_done;

    // Identifier reception and status.
    if (!uart && evt.id_valid) begin
      s_d.id = evt.id_byte[5:0];
      eset[ERR_PAR] = evt.id_byte != pid(evt.id_byte[5:0]);
      s_d.idst = (evt.id_byte[5:0] >= ID_SPEC) ? {1'b1, evt.id_byte[1:0]} : 3'h0;
    end

    // Response bytes and checksum.
    if (!uart && evt.resp_byte_valid) begin
      if (evt.resp_is_chk) begin
        eset[ERR_CHK] = add_eac(s_q.sum, evt.resp_byte) != CHK_GOOD;
      end else begin
        s_d.sum = add_eac(s_q.sum, evt.resp_byte);
        if (s_q.ctrl[2:0] == CMD_RXR) begin
          s_d.fbuf[evt.resp_idx] = evt.resp_byte;
          s_d.txl = s_q.txl + 4'h1;
        end else begin
          s_d.rxl = s_q.rxl + 4'h1;
        end
      end
    end

    // UART receive holding byte.
    if (uart && evt.uart_rx_char) begin
      s_d.urx      = evt.uart_rx_byte;
      s_d.urx_full = 1'b1;
      eset[ERR_OVR] = eset[ERR_OVR] | (s_q.urx_full && !(ar_hs && rsel == 4'h7));
    end

    // Line errors.
    if (evt.bit_drive && evt.sent_level != evt.bus_level) begin
      eset[ERR_BIT] = 1'b1;
      s_d.bit_abort = 1'b1;
    end
    if (evt.stop_sample && !evt.stop_level) begin
      eset[ERR_FRM] = 1'b1;
    end
    if (!uart && !evt.is_master) begin
      eset[ERR_SYNC] = evt.sync_fault;
    end
    if (!uart) begin
      eset[ERR_TOUT] = evt.frame_timeout;
    end
    if (!uart && evt.break_sync && busy && !evt.is_master) begin
      s_d.withdraw = 1'b1;
      s_d.ctrl[2:0] = CMD_RXH_ABORT;
      if (!evt.is_master && s_q.ctrl[2:0] == CMD_TXR) begin
        eset[ERR_BIT] = 1'b1;
      end
      if (!evt.is_master && s_q.ctrl[2:0] == CMD_RXR) begin
        eset[ERR_FRM] = 1'b1;
      end
    end

    // Any LIN error except a refused command or an abort returns to withdrawal.
    error_register = !uart && |(eset & ~((8'h01 << ERR_ABORT) | (8'h01 << ERR_OVR)));
    if (error_register) begin
      s_d.withdraw  = 1'b1;
      s_d.ctrl[2:0] = CMD_RXH_ABORT;
    end

    // Sticky flags: a set in the clearing cycle wins.
    s_d.err = (s_q.err & {8{!eclr}}) | eset;
    s_d.okf = (s_q.okf & ~oclr) | oset;

    // UART mode holds the length fields at zero.
    if (s_d.ctrl[2]) begin
      s_d.rxl = 4'h0;
      s_d.txl = 4'h0;
      s_d.okf[2] = 1'b0;
    end

    // Software reset keeps only the bus channels.
    if (s_q.ctrl[CTRL_SWRES]) begin
      s_d = {s_d[$bits(lufc_state_t)-1 -: 35], s_rst[$bits(lufc_state_t)-36:0]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= s_rst;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign s_axi_awready = s_q.wst == W_IDLE && !s_q.aw_have;
  assign s_axi_wready  = s_q.wst == W_IDLE && !s_q.w_have;
  assign s_axi_bvalid  = s_q.wst == W_RESP;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.rst == R_IDLE;
  assign s_axi_rvalid  = s_q.rst == R_RESP;
  assign s_axi_rresp   = s_q.rresp;
  assign s_axi_rdata   = {24'h00_0000, s_q.rdata};

  assign tx_buf_byte = s_q.fbuf[tx_idx];

  assign ctl.enable              = s_q.ctrl[CTRL_ENA];
  assign ctl.old_protocol_select = s_q.ctrl[CTRL_OLD];
  assign ctl.conf                = s_q.ctrl[5:4];
  assign ctl.command_field       = s_q.ctrl[2:0];
  assign ctl.withdraw            = s_q.withdraw;
  assign ctl.bit_abort           = s_q.bit_abort;
  assign ctl.uart_tx_byte        = s_q.utx;
  assign ctl.tx_checksum         = ~s_q.sum;
  assign ctl.rx_length_field     = s_q.rxl;
  assign ctl.tx_length_field     = s_q.txl;
  assign ctl.id                  = s_q.id;

  assign irq_err = (|s_q.err) && s_q.iren[3];
  assign irq_com = |(s_q.okf & s_q.iren[2:0]);

endmodule : lufc_core

`default_nettype wire

// ### src/lufc_unused_guard.sv
// Holds no logic; the core module carries the whole block.
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ### verification/lufc_monitor.sv
// Checker of the flag, checksum and frame-buffer block, watching its ports only.
// Assumes the bind at the foot attaches it to every lufc_core instance.
`timescale 1ns/100ps
`default_nettype none

module lufc_monitor
  import lufc_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_wvalid,
  input wire lufc_evt_t  evt,
  input wire logic [2:0] tx_idx,
  input wire logic [7:0] tx_buf_byte,
  input wire lufc_ctl_t  ctl,
  input wire logic       irq_err,
  input wire logic       irq_com
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////////
  // Engine control answers to error events, and byte mode length fields.
  chk_bit_abort: assert property (evt.bit_drive && (evt.sent_level != evt.bus_level) |=> ctl.bit_abort)
    else $error("bit mismatch without abort pulse");
  chk_tout_withdraw: assert property (evt.frame_timeout && !ctl.command_field[2] |=> ctl.withdraw)
    else $error("timeout without withdraw");
  chk_break_withdraw: assert property (evt.break_sync && evt.busy && !evt.is_master && !ctl.command_field[2]
    |=> ctl.withdraw)
    else $error("break in data without withdraw");
  chk_withdraw_cmd: assert property (ctl.withdraw |-> ##[0:1] ctl.command_field == CMD_RXH_ABORT)
    else $error("withdraw left a command");
  chk_uart_len: assert property (ctl.command_field[2] && $past(ctl.command_field[2]) |->
    ctl.rx_length_field == 4'h0 && ctl.tx_length_field == 4'h0)
    else $error("length fields not zero in byte mode");

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt lines rise and frame buffer changes only for a cause.
  chk_com_cause: assert property ($rose(irq_com) |-> $past(s_axi_wvalid, 2) || $past(evt.hdr_done
    || evt.rx_resp_done || evt.tx_resp_done || evt.uart_rx_char || evt.uart_tx_char))
    else $error("communication interrupt without cause");
  chk_err_cause: assert property ($rose(irq_err) |-> $past(s_axi_wvalid, 2) || $past(evt.bit_drive
    || evt.stop_sample || evt.sync_fault || evt.frame_timeout || evt.break_sync || evt.resp_byte_valid
    || evt.id_valid || evt.uart_rx_char))
    else $error("error interrupt without cause");
  chk_buf_stable: assert property (!$stable(tx_buf_byte) |-> !$stable(tx_idx) || $past(s_axi_wvalid, 2)
    || $past(evt.resp_byte_valid) || $past(evt.uart_rx_char))
    else $error("buffer byte changed without access");
endmodule : lufc_monitor

bind lufc_core lufc_monitor i_lufc_monitor (
  .aclk        (aclk),
  .aresetn     (aresetn),
  .s_axi_wvalid(s_axi_wvalid),
  .evt         (evt),
  .tx_idx      (tx_idx),
  .tx_buf_byte (tx_buf_byte),
  .ctl         (ctl),
  .irq_err     (irq_err),
  .irq_com     (irq_com)
);

`default_nettype wire

// ### verification/lufc_eng.sv
// Serial engine model: turns requests of the testbench into event pulses.
// Assumes the testbench calls hit between edges and drives busy itself.
`timescale 1ns/100ps
`default_nettype none

module lufc_eng
  import lufc_pkg::*;
(
  input  wire logic      aclk,
  input  wire logic      busy,
  output var  lufc_evt_t evt
);
  lufc_evt_t e = '0;

  ////////////////////////////////////////////////////////////////////////////////
  // Levels follow the testbench; the node is a slave.
  always_comb begin
    evt = e;
    evt.busy = busy;
    evt.is_master = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Raises one event for one cycle, then waits for the flags to land.
  task automatic hit(input int k, input logic [7:0] b, input logic [2:0] i);
    @(posedge aclk);
    e.uart_rx_byte <= b;
    e.resp_byte <= b;
    e.id_byte <= b;
    e.resp_idx <= i;
    e.sent_level <= 1'b1;
    case (k)
      0: e.hdr_done <= 1'b1;
      1: e.rx_resp_done <= 1'b1;
      2: e.tx_resp_done <= 1'b1;
      3: e.uart_rx_char <= 1'b1;
      4: e.uart_tx_char <= 1'b1;
      5: e.bit_drive <= 1'b1;
      6: e.stop_sample <= 1'b1;
      7: e.sync_fault <= 1'b1;
      8: e.frame_timeout <= 1'b1;
      9: e.break_sync <= 1'b1;
      10: e.resp_byte_valid <= 1'b1;
      11: begin
        e.resp_byte_valid <= 1'b1;
        e.resp_is_chk <= 1'b1;
      end
      default: e.id_valid <= 1'b1;
    endcase
    @(posedge aclk);
    e <= '0;
    @(posedge aclk);
  endtask : hit
endmodule : lufc_eng

`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench of the flag block: register bus tasks plus engine events.
// Assumes lufc_core with default parameters and the engine model beside it.
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import lufc_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, busy;
  logic        awready, wready, bvalid, arready, rvalid, irq_err, irq_com;
  logic [7:0]  awaddr, araddr, tx_buf_byte;
  logic [31:0] wdata, rdata, rd_v;
  logic [1:0]  bresp, rresp, rresp_v;
  logic [2:0]  tx_idx;
  lufc_evt_t   evt;
  lufc_ctl_t   ctl;
  int          failures = 0;
  int          compares = 0;
  int          cyc = 0;
  int          ev[4] = '{5, 6, 7, 8};
  int          eb[4] = '{0, 4, 3, 6};

  lufc_core i_lufc_core (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .evt(evt), .tx_idx(tx_idx),
    .tx_buf_byte(tx_buf_byte), .ctl(ctl), .irq_err(irq_err), .irq_com(irq_com));
  lufc_eng i_lufc_eng (.aclk(aclk), .busy(busy), .evt(evt));

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, bus and verdict tasks.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_v = rdata;
    rresp_v = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    rd(a);
    chk(rd_v, x);
  endtask : rdc

  task automatic hit(input int k, input logic [7:0] b);
    i_lufc_eng.hit(k, b, 3'(k == 10 ? b[7] : 1'b0));
  endtask : hit

  function automatic logic [7:0] pid(input logic [5:0] i);
    return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
  endfunction : pid

  task automatic give_verdict;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, hang guard and the test sequence.
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, busy} = '0;
    {awaddr, araddr, wdata, tx_idx} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(OFF_STAT, 32'h0000_0000);
    rdc(OFF_LEN, 32'h0000_0000);
    rd(8'h20);
    chk(32'(rresp_v), 32'(RESP_SERR));
    wr(OFF_IREN, 32'h0000_0004);
    wr(OFF_CTRL, 32'h0000_0009);
    chk(32'(ctl.command_field), 32'(CMD_TXH));
    hit(0, 8'h00);
    chk(32'(irq_com), 32'h1);
    rdc(OFF_STAT, 32'h0000_0004);
    wr(OFF_STAT, 32'h0000_0004);
    chk(32'(irq_com), 32'h0);
    hit(1, 8'h00);
    hit(2, 8'h00);
    rdc(OFF_STAT, 32'h0000_0003);
    wr(OFF_STAT, 32'h0000_000F);
    wr(OFF_IREN, 32'h0000_0008);
    for (int n = 0; n < 4; n++) begin
      wr(OFF_CTRL, 32'h0000_000A);
      hit(ev[n], 8'h00);
      rdc(OFF_ERR, 32'(1 << eb[n]));
      chk(32'(ctl.command_field), 32'h0);
      rdc(OFF_STAT, 32'h0000_0008);
      chk(32'(irq_err), 32'h1);
      wr(OFF_STAT, 32'h0000_0008);
      rdc(OFF_ERR, 32'h0000_0000);
    end
    wr(OFF_CTRL, 32'h0000_000A);
    busy <= 1'b1;
    hit(9, 8'h00);
    busy <= 1'b0;
    rdc(OFF_ERR, 32'h0000_0010);
    wr(OFF_STAT, 32'h0000_0008);
    for (int k = 0; k < 4; k++) begin
      hit(12, pid(6'(8'h3C + k)));
      rd(OFF_STAT);
      chk(32'(rd_v[7:5]), 32'(4 + k));
    end
    hit(12, pid(6'h01));
    rd(OFF_STAT);
    chk(32'(rd_v[7]), 32'h0);
    hit(12, pid(6'h01) ^ 8'h80);
    rdc(OFF_ERR, 32'h0000_0004);
    rdc(OFF_ID, 32'h0000_00C1);
    wr(OFF_STAT, 32'h0000_0008);
    hit(12, pid(6'h3C));
    for (int r = 0; r < 3; r++) begin
      wr(OFF_CTRL, r == 2 ? 32'h0000_004A : 32'h0000_000A);
      i_lufc_eng.hit(10, 8'h12, 3'h0);
      i_lufc_eng.hit(10, 8'hF0, 3'h1);
      hit(11, r == 0 ? 8'hC0 : (r == 1 ? 8'hC1 : 8'hFC));
      chk(32'(ctl.tx_checksum), r == 2 ? 32'h0000_00FC : 32'h0000_00C0);
      hit(1, 8'h00);
      rdc(OFF_ERR, r == 1 ? 32'h0000_0002 : 32'h0000_0000);
      wr(OFF_STAT, 32'h0000_000F);
    end
    hit(0, 8'h00);
    rdc(OFF_LEN, 32'h0000_0088);
    wr(OFF_SEL, 32'h0000_0000);
    rdc(OFF_DATA, 32'h0000_0012);
    rdc(OFF_DATA, 32'h0000_00F0);
    wr(OFF_SEL, 32'h0000_0007);
    wr(OFF_DATA, 32'h0000_00A5);
    wr(OFF_DATA, 32'h0000_005A);
    tx_idx <= 3'h7;
    @(posedge aclk);
    chk(32'(tx_buf_byte), 32'h0000_00A5);
    tx_idx <= 3'h0;
    @(posedge aclk);
    chk(32'(tx_buf_byte), 32'h0000_005A);
    rdc(OFF_SEL, 32'h0000_0001);
    busy <= 1'b1;
    wr(OFF_CTRL, 32'h0000_000A);
    rdc(OFF_ERR, 32'h0000_0020);
    wr(OFF_STAT, 32'h0000_0008);
    wr(OFF_CTRL, 32'h0000_0008);
    rdc(OFF_ERR, 32'h0000_0080);
    busy <= 1'b0;
    wr(OFF_STAT, 32'h0000_000F);
    wr(OFF_LEN, 32'h0000_0034);
    rdc(OFF_LEN, 32'h0000_0034);
    wr(OFF_CTRL, 32'h0000_000E);
    rdc(OFF_LEN, 32'h0000_0000);
    wr(OFF_LEN, 32'h0000_0056);
    rdc(OFF_LEN, 32'h0000_0000);
    hit(3, 8'h11);
    hit(3, 8'h22);
    rdc(OFF_ERR, 32'h0000_0020);
    rdc(OFF_STAT, 32'h0000_0089);
    rdc(OFF_DATA, 32'h0000_0022);
    rd(OFF_STAT);
    chk(32'(rd_v[3]), 32'h0);
    wr(OFF_STAT, 32'h0000_000F);
    hit(0, 8'h00);
    hit(4, 8'h00);
    rdc(OFF_STAT, 32'h0000_0082);
    hit(6, 8'h00);
    rdc(OFF_ERR, 32'h0000_0010);
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
